// ---- rtl/spt_self_test.v ----
`include "spt_map.vh"
module spt_self_test #(
	parameter CLK_HZ    = `SPT_CLK_HZ,
	parameter FATAL_CYC = `SPT_FATAL_MS * (`SPT_CLK_HZ / 1000),
	parameter NONF_CYC  = `SPT_NONFATAL_MS * (`SPT_CLK_HZ / 1000),
	parameter FRZ_CYC   = `SPT_FREEZE_MS * (`SPT_CLK_HZ / 1000)
) (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	input  wire        acc_disable_sw,
	output reg         disable_led_ff,
	output reg  [7:0]  status_disp_ff,
	output reg         wdog_service_ff
);
	////////////////////////////////////////////////////////////////////////
	// Step codes and state machine
	localparam [4:0] ST_FWSUM = 5'd0, ST_LATCH = 5'd1, ST_ADDR = 5'd2, ST_ZERO = 5'd3,
		ST_ONES = 5'd4, ST_WDOG = 5'd5, ST_RING = 5'd6, ST_RINGI = 5'd7,
		ST_COPY = 5'd8, ST_TYPE = 5'd9, ST_VER = 5'd10, ST_CPSUM = 5'd11,
		ST_CHK = 5'd12, ST_UCHK = 5'd13, ST_LINK = 5'd14, ST_ADC = 5'd15,
		ST_SUB = 5'd16, ST_ALRT = 5'd17, ST_TXSUB = 5'd18, ST_TXDEV = 5'd19,
		ST_RXLVL = 5'd20, ST_DEC = 5'd21;
	localparam [5:0] S_RUN = 6'b000001, S_SHOW = 6'b000010, S_HALT = 6'b000100,
		S_FRZ = 6'b001000, S_DONE = 6'b010000, S_DEAD = 6'b100000;

	reg  [5:0]  state_ff, nxt_state;
	reg  [4:0]  step_ff, nxt_step;
	reg  [7:0]  stim_ff;
	reg  [7:0]  ref_ff;
	reg  [7:0]  result_ff;
	reg         adv_ff;
	reg         fail_ff;
	reg         fatal_ff;
	reg         eebyp_ff;
	reg         dash_ff;
	reg         load_t;
	reg  [31:0] load_v;
	wire        t_exp;
	reg  [2:0]  sw_sync_ff;
	reg         sw_lvl_ff;
	wire        sw_on;

	// Three-stage synchroniser; level moves only when stages two and three agree
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sw_sync_ff <= 3'b000;
			sw_lvl_ff  <= 1'b0;
		end else begin
			sw_sync_ff <= {sw_sync_ff[1:0], acc_disable_sw};
			if (sw_sync_ff[1] == sw_sync_ff[2])
				sw_lvl_ff <= sw_sync_ff[2];
		end
	end
	assign sw_on = sw_lvl_ff;

	// Error code: high bit marks a fatal step, low bits the step number
	function [7:0] err_code;
		input [4:0] s;
		begin
			err_code = {(s <= `SPT_LAST_DIGITAL) ? 1'b1 : 1'b0, 2'b00, s};
		end
	endfunction

	// Reference data comparison per step; software supplies both sides except at ST_CHK and ST_UCHK, which test against the erased code
	function step_ok;
		input [4:0] s;
		input [7:0] got;
		input [7:0] exp;
		input       fl;
		begin
			case (s)
				ST_CHK:  step_ok = (got != `SPT_CHECK_ERASED);
				ST_UCHK: step_ok = (got != `SPT_CHECK_ERASED);
				ST_RINGI: step_ok = (got == ~exp);
				default: step_ok = (got == exp) && !fl;
			endcase
		end
	endfunction

	spt_hold_timer #(.W(32)) u_timer (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.load       (load_t),
		.load_val   (load_v),
		.expired_ff (t_exp)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always @* begin
		nxt_state = state_ff;
		nxt_step  = step_ff;
		load_t    = 1'b0;
		load_v    = 32'h0000_0000;
		case (state_ff)
			S_RUN: begin
				// advance in fixed order on verdict
				if (adv_ff) begin
					if (!step_ok(step_ff, result_ff, ref_ff, fail_ff)) begin
						load_t    = 1'b1;
						nxt_state = S_SHOW;
						load_v = (step_ff <= `SPT_LAST_DIGITAL) ? FATAL_CYC : NONF_CYC;
					end else if (step_ff == ST_DEC) begin
						nxt_state = S_DONE;
					end else begin
						nxt_step = step_ff + 5'd1;
					end
				end
			end
			S_SHOW: begin
				if (!fatal_ff && sw_on)
					nxt_state = S_FRZ;
				else if (t_exp) begin
					if (fatal_ff)
						nxt_state = S_DEAD;
					else if (step_ff == ST_DEC)
						nxt_state = S_DONE;
					else begin
						nxt_state = S_RUN;
						nxt_step  = step_ff + 5'd1;
					end
				end
			end
			S_FRZ:   nxt_state = S_FRZ;
			S_DEAD:  nxt_state = S_DEAD;
			S_DONE:  nxt_state = S_DONE;
			default: nxt_state = S_RUN;
		endcase
	end

	// Sequencer registers and front-panel outputs
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff        <= S_RUN;
			step_ff         <= ST_FWSUM;
			fatal_ff        <= 1'b0;
			eebyp_ff        <= 1'b1;
			dash_ff         <= 1'b0;
			disable_led_ff  <= 1'b0;
			status_disp_ff  <= `SPT_DISP_BLANK;
			wdog_service_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			step_ff  <= nxt_step;
			if (state_ff == S_RUN && adv_ff && step_ff == ST_COPY &&
			    step_ok(step_ff, result_ff, ref_ff, fail_ff))
				eebyp_ff <= 1'b0;
			if (state_ff == S_RUN && nxt_state == S_SHOW) begin
				fatal_ff       <= (step_ff <= `SPT_LAST_DIGITAL);
				status_disp_ff <= err_code(step_ff);
			end else if (state_ff == S_SHOW && nxt_state == S_RUN) begin
				status_disp_ff <= dash_ff ? `SPT_DISP_DASHES : `SPT_DISP_BLANK;
			end
			if (state_ff == S_RUN && nxt_step == ST_ADC && step_ff == ST_LINK) begin
				dash_ff        <= 1'b1;
				disable_led_ff <= 1'b1;
				status_disp_ff <= `SPT_DISP_DASHES;
			end
			if (nxt_state == S_DEAD)
				wdog_service_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: write path takes address and data in either order
	reg        aw_got_ff, w_got_ff;
	reg [7:0]  aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0]  w_strb_ff;
	wire       wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
	wire       wr_ctrl = (aw_addr_ff == `SPT_REG_CTRL);
	// Verdict is only accepted while the sequencer runs a step
	wire       run_now = (state_ff == S_RUN);

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SPT_RESP_OKAY;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h0000_0000;
			w_strb_ff     <= 4'h0;
			adv_ff        <= 1'b0;
			fail_ff       <= 1'b0;
			stim_ff       <= 8'h00;
			ref_ff        <= 8'h00;
			result_ff     <= 8'h00;
		end else begin
			adv_ff <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff     <= 1'b1;
				aw_addr_ff    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff     <= 1'b1;
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SPT_RESP_OKAY;
				case (aw_addr_ff)
					`SPT_REG_CTRL: begin
						// Verdict write: byte 0 carries advance and fail, byte 1 the result
						if (w_strb_ff[0] && w_data_ff[`SPT_CTRL_ADV] && run_now) begin
							adv_ff  <= 1'b1;
							fail_ff <= w_data_ff[`SPT_CTRL_FAIL];
						end
						if (w_strb_ff[1])
							result_ff <= w_data_ff[15:8];
					end
					`SPT_REG_STIM: if (w_strb_ff[0]) stim_ff <= w_data_ff[7:0];
					`SPT_REG_REF:  if (w_strb_ff[0]) ref_ff <= w_data_ff[7:0];
					`SPT_REG_STATUS, `SPT_REG_RESULT: s_axi_bresp <= `SPT_RESP_OKAY;
					default: s_axi_bresp <= `SPT_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read path: one-cycle answer after address is taken
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SPT_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `SPT_RESP_OKAY;
				case (s_axi_araddr)
					`SPT_REG_CTRL:   s_axi_rdata <= {16'h0000, result_ff, 7'h00, sw_on};
					`SPT_REG_STATUS: s_axi_rdata <= {11'h000, step_ff, status_disp_ff,
						eebyp_ff, wdog_service_ff, dash_ff, disable_led_ff,
						state_ff[4], state_ff[3], ~(state_ff[4] | state_ff[5]),
						fatal_ff};
					`SPT_REG_RESULT: s_axi_rdata <= {24'h000000, result_ff};
					`SPT_REG_STIM:   s_axi_rdata <= {24'h000000, stim_ff};
					`SPT_REG_REF:    s_axi_rdata <= {24'h000000, ref_ff};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SPT_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ---- shared/spt_map.vh ----
`ifndef SPT_MAP_VH
`define SPT_MAP_VH
// Register byte offsets
`define SPT_REG_CTRL      8'h00
`define SPT_REG_STATUS    8'h04
`define SPT_REG_RESULT    8'h08
`define SPT_REG_STIM      8'h0C
`define SPT_REG_REF       8'h10
// Control fields
`define SPT_CTRL_ADV      0
`define SPT_CTRL_FAIL     1
`define SPT_CTRL_SWITCH   2
// Status fields
`define SPT_ST_FATAL      0
`define SPT_ST_BUSY       1
`define SPT_ST_FROZEN     2
`define SPT_ST_DONE       3
`define SPT_ST_DISLED     4
`define SPT_ST_DASHES     5
`define SPT_ST_WDOG       6
`define SPT_ST_EEBYP      7
`define SPT_ST_DISP_LSB   8
`define SPT_ST_STEP_LSB   16
// Timing
`define SPT_CLK_HZ        200000000
`define SPT_FATAL_MS      5000
`define SPT_NONFATAL_MS   2000
`define SPT_FREEZE_MS     2000
`define SPT_EE_UPDATE_MS  15000
// Display codes
`define SPT_DISP_BLANK    8'h00
`define SPT_DISP_DASHES   8'h2D
`define SPT_CHECK_DONE    8'h00
`define SPT_CHECK_ERASED  8'hFF
// Step count: 22 checks in fixed order
`define SPT_NUM_STEPS     5'd22
`define SPT_LAST_DIGITAL  5'd14
`define SPT_RESP_OKAY     2'b00
`define SPT_RESP_SLVERR   2'b10
`endif

// ---- rtl/spt_hold_timer.v ----
`include "spt_map.vh"
// Down-counter that times a displayed error code
module spt_hold_timer #(
	parameter W = 32
) (
	input  wire         core_clk,
	input  wire         rstn,
	input  wire         load,
	input  wire [W-1:0] load_val,
	output reg          expired_ff
);
	reg [W-1:0] cnt_ff;
	reg         run_ff;

	// Count down after load; pulse expiry once at zero
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff     <= {W{1'b0}};
			run_ff     <= 1'b0;
			expired_ff <= 1'b0;
		end else if (load) begin
			cnt_ff     <= load_val;
			run_ff     <= 1'b1;
			expired_ff <= 1'b0;
		end else if (run_ff && cnt_ff == {W{1'b0}}) begin
			run_ff     <= 1'b0;
			expired_ff <= 1'b1;
		end else begin
			cnt_ff     <= run_ff ? cnt_ff - {{(W-1){1'b0}}, 1'b1} : cnt_ff;
			expired_ff <= 1'b0;
		end
	end
endmodule

// ---- tb/spt_checker.sv ----
`include "spt_map.vh"
module spt_checker #(
	parameter FATAL_CYC = 20,
	parameter NONF_CYC  = 20
) (
	input logic        core_clk,
	input logic        rstn,
	input logic        s_axi_awready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        disable_led_ff,
	input logic [7:0]  status_disp_ff,
	input logic        wdog_service_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Fatal codes carry the top display bit
	sequence fatal_shown;
		$rose(status_disp_ff[7]);
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address open during response");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	bad_addr_a: assert property (rd_taken ##0 (s_axi_araddr > 8'h10) |=> s_axi_rresp == `SPT_RESP_SLVERR)
		else $error("unmapped read not refused");
	fatal_hold_a: assert property (fatal_shown |-> wdog_service_ff [*8])
		else $error("watchdog dropped before fatal hold");
	wdog_drop_a: assert property (fatal_shown |-> ##[1:100] !wdog_service_ff)
		else $error("watchdog still serviced after fatal");
	wdog_stay_a: assert property (!wdog_service_ff |=> !wdog_service_ff)
		else $error("sequencer resumed after fatal");
	led_dash_a: assert property ($rose(disable_led_ff) |-> ##[0:1] status_disp_ff == `SPT_DISP_DASHES)
		else $error("indicator lit without dashes");
endmodule
bind spt_self_test spt_checker #(.FATAL_CYC(FATAL_CYC), .NONF_CYC(NONF_CYC)) chk_i (
	.core_clk(core_clk), .rstn(rstn), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.disable_led_ff(disable_led_ff), .status_disp_ff(status_disp_ff),
	.wdog_service_ff(wdog_service_ff));

// ---- tb/spt_panel.sv ----
// Front-panel switch; level follows the operator a cycle late
module spt_panel (
	input  logic core_clk,
	input  logic press,
	output logic acc_disable_sw
);
	timeunit 1ns;
	timeprecision 1ps;
	initial acc_disable_sw = 1'b0;
	always @(posedge core_clk) begin
		acc_disable_sw <= press;
	end
endmodule

// ---- tb/station_power_on_self_test_test.sv ----
`include "spt_map.vh"
module station_power_on_self_test_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	logic        core_clk = 0, rstn = 0, press = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdat;
	logic [1:0]  rr, br;
	wire         awready, wready, bvalid, arready, rvalid, sw, led, wdog;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [7:0]   disp;
	int          err_total = 0, total_checks = 0, cyc = 0;
	spt_self_test #(.FATAL_CYC(HOLD), .NONF_CYC(HOLD)) uut (.core_clk(core_clk), .rstn(rstn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.acc_disable_sw(sw), .disable_led_ff(led), .status_disp_ff(disp), .wdog_service_ff(wdog));
	spt_panel panel (.core_clk(core_clk), .press(press), .acc_disable_sw(sw));
	initial forever #2.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard, well above the longest run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Each channel released at its own handshake; leading edge avoids double drive
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		br = bresp; bready <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		araddr <= a; arvalid <= 1; rready <= 1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rdat = rdata; rr = rresp; rready <= 0;
	endtask
	task adv(input logic [7:0] r, input logic f);
		wr(`SPT_REG_CTRL, {16'h0000, r, 6'h00, f, 1'b1});
	endtask
	// Passing verdicts: inverse ring pattern at 7, written check bytes at 12 and 13
	task run(input int a, input int b);
		for (int i = a; i < b; i++) adv(i == 7 ? 8'hA5 : (i == 12 || i == 13) ? 8'h00 : 8'h5A, 1'b0);
	endtask
	task boot;
		rstn <= 0; wt(2); rstn <= 1;
		wr(`SPT_REG_REF, 32'h0000005A);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(2); rstn <= 1;
		rd(`SPT_REG_STATUS);
		chk("step", rdat[20:16], 0);
		chk("ee_bypass", rdat[7], 1);
		wr(`SPT_REG_REF, 32'h0000005A);
		chk("bresp", br, `SPT_RESP_OKAY);
		run(0, 9); rd(`SPT_REG_STATUS);
		chk("ee_bypass", rdat[7], 0);
		chk("step", rdat[20:16], 9);
		run(9, 15); wt(1);
		chk("led", led, 1);
		chk("disp", disp, `SPT_DISP_DASHES);
		adv(8'h00, 1'b1); wt(2);
		chk("disp", disp, 8'h0F);
		wt(3 * HOLD); rd(`SPT_REG_STATUS);
		chk("step", rdat[20:16], 16);
		chk("wdog", wdog, 1);
		run(16, 22); rd(`SPT_REG_STATUS);
		chk("done", rdat[3], 1);
		boot; run(0, 16); adv(8'h00, 1'b1);
		press <= 1; wt(3 * HOLD); press <= 0; adv(8'h5A, 1'b0); rd(`SPT_REG_STATUS);
		chk("frozen", rdat[2], 1);
		chk("step", rdat[20:16], 16);
		for (int s = 0; s < 15; s++) begin
			boot; run(0, s);
			adv((s == 12 || s == 13) ? 8'hFF : 8'h00, 1'b0); wt(2);
			chk("disp", disp, {3'b100, s[4:0]});
			chk("wdog", wdog, 1);
			wt(3 * HOLD);
			chk("wdog", wdog, 0);
			adv(8'h5A, 1'b0); rd(`SPT_REG_STATUS);
			chk("step", rdat[20:16], s);
		end
		rd(8'h20);
		chk("resp", rr, `SPT_RESP_SLVERR);
		wr(8'h20, 32'h00000000);
		chk("bresp", br, `SPT_RESP_SLVERR);
		end_sim;
	end
endmodule
